// File: hw/pphy_defines.svh
// Offsets, field positions, reset values and timing counts of the PHY bank
`ifndef PPHY_DEFINES_SVH
`define PPHY_DEFINES_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PPHY_IDX_CTRL 8'h00
`define PPHY_IDX_STAT 8'h02
`define PPHY_IDX_IDLO 8'h04
`define PPHY_IDX_ACTL 8'h10
`define PPHY_IDX_AST 8'h11
`define PPHY_IDX_ISTAT 8'h12
`define PPHY_IDX_IMASK 8'h13
// ----------------------------------------------------------------------
// Basic control fields
// ----------------------------------------------------------------------
`define PPHY_C_LOOP 14
`define PPHY_C_SPD 13
`define PPHY_C_ANEN 12
`define PPHY_C_PD 11
`define PPHY_C_RST_AN 9
`define PPHY_C_DPX 8
`define PPHY_C_ALTX 5
`define PPHY_C_FMDIX 4
`define PPHY_C_DMDIX 3
`define PPHY_C_RSVD 2
`define PPHY_C_TXD 1
`define PPHY_C_LEDD 0
`define PPHY_CTRL_RST 16'h1020
`define PPHY_CTRL_WMASK 16'h793f
// ----------------------------------------------------------------------
// Basic status fields
// ----------------------------------------------------------------------
`define PPHY_STAT_CONST 16'h7808
`define PPHY_S_ANDONE 5
`define PPHY_S_LINK 2
// ----------------------------------------------------------------------
// Alias control (x10) and alias status (x11) fields
// ----------------------------------------------------------------------
`define PPHY_A_LEDD 15
`define PPHY_A_TXD 14
`define PPHY_A_RST_AN 13
`define PPHY_A_RSVD 12
`define PPHY_A_PD 11
`define PPHY_A_DMDIX 10
`define PPHY_A_FMDIX 9
`define PPHY_A_LOOP 8
`define PPHY_A_ANEN 7
`define PPHY_A_SPD 6
`define PPHY_A_DPX 5
`define PPHY_A_ALTX 15
`define PPHY_A_ANDONE 6
`define PPHY_A_LINK 5
// ----------------------------------------------------------------------
// Interrupt bits and timing
// ----------------------------------------------------------------------
`define PPHY_EVT_LINK 0
`define PPHY_EVT_AN 1
`define PPHY_EVT_W 2
`define PPHY_CLK_NS 8
`define PPHY_RESTART_NS 80
`define PPHY_RESTART_CYC \
   ((`PPHY_RESTART_NS + `PPHY_CLK_NS - 1) / `PPHY_CLK_NS)
`endif

// File: hw/pphy_pkg.sv
// Types shared by the PHY register bank modules
package pphy_pkg;
   // Restart sequencer states, Gray coded along idle-pulse-settle
   typedef enum logic [1:0] {
      an_idle = 2'b00,
      an_pulse = 2'b01,
      an_settle = 2'b11
   } pphy_an_state_t;
   typedef logic [15:0] pphy_word_t;
endpackage : pphy_pkg

// File: hw/pphy_stat_if.sv
// Line state and event pulses from the status tracker to the bank
`timescale 1ns/100ps
interface pphy_stat_if;
   logic link_up;
   logic an_done;
   logic evt_link;
   logic evt_an;
   modport src (output link_up, output an_done, output evt_link,
      output evt_an);
   modport dst (input link_up, input an_done, input evt_link,
      input evt_an);
endinterface : pphy_stat_if

// File: hw/pphy_status_track.sv
// Registers the PHY line state and flags link changes and negotiation completion
`timescale 1ns/100ps
module pphy_status_track (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // PHY line state
   input wire logic link_up_in,
   input wire logic an_complete_in,
   // Toward the bank
   pphy_stat_if.src st
);
   logic link_reg, link_next, an_reg, an_next;
   logic evl_reg, evl_next, eva_reg, eva_next;

   // Next state and change detection
   always_comb begin
      link_next = link_up_in;
      an_next = an_complete_in;
      evl_next = link_up_in != link_reg;
      eva_next = an_complete_in && !an_reg;
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_reg <= 1'b0;
         an_reg <= 1'b0;
         evl_reg <= 1'b0;
         eva_reg <= 1'b0;
      end else begin
         link_reg <= link_next;
         an_reg <= an_next;
         evl_reg <= evl_next;
         eva_reg <= eva_next;
      end
   end

   assign st.link_up = link_reg;
   assign st.an_done = an_reg;
   assign st.evt_link = evl_reg;
   assign st.evt_an = eva_reg;
endmodule : pphy_status_track

// File: hw/pphy_an_restart.sv
// Self-clearing auto-negotiation restart sequencer
`timescale 1ns/100ps
`include "pphy_defines.svh"
module pphy_an_restart #(
   parameter int HOLD = `PPHY_RESTART_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request and state
   input wire logic start,
   output logic busy,
   output logic restart_out
);
   pphy_pkg::pphy_an_state_t st_reg, st_next;
   logic [7:0] cnt_reg, cnt_next;

   generate
      if (HOLD < 1 || HOLD > 255) begin : g_bad
         $error("pphy_an_restart: HOLD must be 1 to 255");
      end
   endgenerate

   // Pulse for HOLD cycles, settle one cycle, then accept again
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      case (st_reg)
         pphy_pkg::an_idle: begin
            if (start) begin
               st_next = pphy_pkg::an_pulse;
               cnt_next = 8'(HOLD - 1);
            end
         end
         pphy_pkg::an_pulse: begin
            if (cnt_reg == 8'h00) begin
               st_next = pphy_pkg::an_settle;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         default: begin
            st_next = pphy_pkg::an_idle;
         end
      endcase
   end

   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= pphy_pkg::an_idle;
         cnt_reg <= 8'h00;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
      end
   end

   assign busy = st_reg != pphy_pkg::an_idle;
   assign restart_out = st_reg == pphy_pkg::an_pulse;
endmodule : pphy_an_restart

// File: hw/pphy_bank.sv
// Port 2 PHY basic control, status and identifier registers on APB
//
// Operation
// - Control bit 14 loops receive pair back out transmit pair; resets 0
// - Bit 13 forces 100 or 10 Mbps, bit 8 full or half duplex
// - Control bit 12 enables auto-negotiation; resets to one
// - Control bit 11 powers the PHY down; resets to zero
// - Writing one to control bit 9 restarts auto-negotiation
// - Control bit 5 picks the alternate crossover algorithm; resets to one
// - Bit 4 forces crossed wiring, bit 3 disables automatic crossover
// - Bit 1 disables transmitter, bit 0 disables the port LEDs
// - Status bits 14 to 11 read one, bit 15 reads zero
// - Status bit 5 reads one once auto-negotiation has completed
// - Status bit 2 reads one while the link is up
// - Status bit 3 reads one, status bit 0 reads zero
// - Identifier low register returns a fixed sixteen-bit constant
`timescale 1ns/100ps
`include "pphy_defines.svh"
module pphy_bank #(
   parameter int ADDR_W = 10,
   parameter logic [15:0] PHY_ID_LOW = 16'h5a5a, // Value is arbitrary
   parameter int RESTART_HOLD = `PPHY_RESTART_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // PHY line state
   input wire logic link_up_in,
   input wire logic an_complete_in,
   // PHY controls
   output logic loopback_en,
   output logic force_speed_100,
   output logic force_full_duplex,
   output logic an_enable,
   output logic power_down,
   output logic an_restart,
   output logic alt_crossover_algorithm_select,
   output logic force_mdix,
   output logic auto_mdix_disable,
   output logic transmit_disable,
   output logic led_disable,
   // Interrupt
   output logic irq
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   pphy_stat_if st ();
   pphy_pkg::pphy_word_t ctrl_reg, ctrl_next;
   pphy_pkg::pphy_word_t ctrl_rd, stat_rd, actl_rd, ast_rd;
   logic [`PPHY_EVT_W-1:0] istat_reg, istat_next;
   logic [`PPHY_EVT_W-1:0] imask_reg, imask_next, evt_vec;
   logic [31:0] prdata_reg, prdata_next, rd_word;
   logic hit_ctrl, hit_stat, hit_idlo, hit_actl, hit_ast;
   logic hit_istat, hit_imask, hit_any;
   logic wr, rd_setup, restart_req, restart_busy;
   logic [7:0] idx;

   generate
      if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
         $error("pphy_bank: ADDR_W must be 10 to 32");
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------------
   pphy_status_track u_track (
      .pclk(pclk),
      .presetn(presetn),
      .link_up_in(link_up_in),
      .an_complete_in(an_complete_in),
      .st(st.src)
   );

   pphy_an_restart #(.HOLD(RESTART_HOLD)) u_restart (
      .pclk(pclk),
      .presetn(presetn),
      .start(restart_req),
      .busy(restart_busy),
      .restart_out(an_restart)
   );

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   assign idx = paddr[9:2];
   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;

   // Word-aligned hit on one register, else no hit
   always_comb begin
      hit_ctrl = 1'b0;
      hit_stat = 1'b0;
      hit_idlo = 1'b0;
      hit_actl = 1'b0;
      hit_ast = 1'b0;
      hit_istat = 1'b0;
      hit_imask = 1'b0;
      if (paddr[1:0] != 2'b00 || (ADDR_W > 10 && paddr >> 10 != 0)) begin
         hit_ctrl = 1'b0;
      end else if (idx == `PPHY_IDX_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (idx == `PPHY_IDX_STAT) begin
         hit_stat = 1'b1;
      end else if (idx == `PPHY_IDX_IDLO) begin
         hit_idlo = 1'b1;
      end else if (idx == `PPHY_IDX_ACTL) begin
         hit_actl = 1'b1;
      end else if (idx == `PPHY_IDX_AST) begin
         hit_ast = 1'b1;
      end else if (idx == `PPHY_IDX_ISTAT) begin
         hit_istat = 1'b1;
      end else if (idx == `PPHY_IDX_IMASK) begin
         hit_imask = 1'b1;
      end
   end
   assign hit_any = hit_ctrl | hit_stat | hit_idlo | hit_actl | hit_ast
      | hit_istat | hit_imask;

   // ----------------------------------------------------------------------
   // Read views; both locations of an aliased bit show one flop
   // ----------------------------------------------------------------------
   always_comb begin
      ctrl_rd = ctrl_reg & `PPHY_CTRL_WMASK;
      ctrl_rd[`PPHY_C_RST_AN] = restart_busy;
      stat_rd = `PPHY_STAT_CONST;
      stat_rd[`PPHY_S_ANDONE] = st.an_done;
      stat_rd[`PPHY_S_LINK] = st.link_up;
      actl_rd = 16'h0000;
      actl_rd[`PPHY_A_LEDD] = ctrl_reg[`PPHY_C_LEDD];
      actl_rd[`PPHY_A_TXD] = ctrl_reg[`PPHY_C_TXD];
      actl_rd[`PPHY_A_RST_AN] = restart_busy;
      actl_rd[`PPHY_A_RSVD] = ctrl_reg[`PPHY_C_RSVD];
      actl_rd[`PPHY_A_PD] = ctrl_reg[`PPHY_C_PD];
      actl_rd[`PPHY_A_DMDIX] = ctrl_reg[`PPHY_C_DMDIX];
      actl_rd[`PPHY_A_FMDIX] = ctrl_reg[`PPHY_C_FMDIX];
      actl_rd[`PPHY_A_LOOP] = ctrl_reg[`PPHY_C_LOOP];
      actl_rd[`PPHY_A_ANEN] = ctrl_reg[`PPHY_C_ANEN];
      actl_rd[`PPHY_A_SPD] = ctrl_reg[`PPHY_C_SPD];
      actl_rd[`PPHY_A_DPX] = ctrl_reg[`PPHY_C_DPX];
      ast_rd = 16'h0000;
      ast_rd[`PPHY_A_ALTX] = ctrl_reg[`PPHY_C_ALTX];
      ast_rd[`PPHY_A_ANDONE] = st.an_done;
      ast_rd[`PPHY_A_LINK] = st.link_up;
   end

   // Read mux, sampled in the setup cycle
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_word = {16'h0000, ctrl_rd};
      end else if (hit_stat) begin
         rd_word = {16'h0000, stat_rd};
      end else if (hit_idlo) begin
         rd_word = {16'h0000, PHY_ID_LOW};
      end else if (hit_actl) begin
         rd_word = {16'h0000, actl_rd};
      end else if (hit_ast) begin
         rd_word = {16'h0000, ast_rd};
      end else if (hit_istat) begin
         rd_word = {30'h0, istat_reg};
      end else if (hit_imask) begin
         rd_word = {30'h0, imask_reg};
      end
   end

   // ----------------------------------------------------------------------
   // Control state, shared by the basic and alias locations
   // ----------------------------------------------------------------------
   always_comb begin
      ctrl_next = ctrl_reg;
      restart_req = 1'b0;
      if (wr && hit_ctrl) begin
         ctrl_next = pwdata[15:0] & `PPHY_CTRL_WMASK;
         restart_req = pwdata[`PPHY_C_RST_AN];
      end else if (wr && hit_actl) begin
         ctrl_next[`PPHY_C_LEDD] = pwdata[`PPHY_A_LEDD];
         ctrl_next[`PPHY_C_TXD] = pwdata[`PPHY_A_TXD];
         ctrl_next[`PPHY_C_RSVD] = pwdata[`PPHY_A_RSVD];
         ctrl_next[`PPHY_C_PD] = pwdata[`PPHY_A_PD];
         ctrl_next[`PPHY_C_DMDIX] = pwdata[`PPHY_A_DMDIX];
         ctrl_next[`PPHY_C_FMDIX] = pwdata[`PPHY_A_FMDIX];
         ctrl_next[`PPHY_C_LOOP] = pwdata[`PPHY_A_LOOP];
         ctrl_next[`PPHY_C_ANEN] = pwdata[`PPHY_A_ANEN];
         ctrl_next[`PPHY_C_SPD] = pwdata[`PPHY_A_SPD];
         ctrl_next[`PPHY_C_DPX] = pwdata[`PPHY_A_DPX];
         restart_req = pwdata[`PPHY_A_RST_AN];
      end else if (wr && hit_ast) begin
         ctrl_next[`PPHY_C_ALTX] = pwdata[`PPHY_A_ALTX];
      end
   end

   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `PPHY_CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Control outputs straight from the flops
   assign loopback_en = ctrl_reg[`PPHY_C_LOOP];
   assign force_speed_100 = ctrl_reg[`PPHY_C_SPD];
   assign force_full_duplex = ctrl_reg[`PPHY_C_DPX];
   assign an_enable = ctrl_reg[`PPHY_C_ANEN];
   assign power_down = ctrl_reg[`PPHY_C_PD];
   assign alt_crossover_algorithm_select = ctrl_reg[`PPHY_C_ALTX];
   assign force_mdix = ctrl_reg[`PPHY_C_FMDIX];
   assign auto_mdix_disable = ctrl_reg[`PPHY_C_DMDIX];
   assign transmit_disable = ctrl_reg[`PPHY_C_TXD];
   assign led_disable = ctrl_reg[`PPHY_C_LEDD];

   // ----------------------------------------------------------------------
   // Interrupts: sticky events, write one to clear, set wins
   // ----------------------------------------------------------------------
   assign evt_vec = {st.evt_an, st.evt_link};

   always_comb begin
      istat_next = istat_reg;
      imask_next = imask_reg;
      if (wr && hit_istat) begin
         istat_next = istat_reg & ~pwdata[`PPHY_EVT_W-1:0];
      end
      if (wr && hit_imask) begin
         imask_next = pwdata[`PPHY_EVT_W-1:0];
      end
      istat_next = istat_next | evt_vec;
   end

   // Interrupt registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_reg <= '0;
         imask_reg <= '0;
      end else begin
         istat_reg <= istat_next;
         imask_reg <= imask_next;
      end
   end

   assign irq = |(istat_reg & imask_reg);

   // ----------------------------------------------------------------------
   // APB answer: no wait states, error on unmapped address
   // ----------------------------------------------------------------------
   always_comb begin
      prdata_next = prdata_reg;
      if (rd_setup) begin
         prdata_next = rd_word;
      end
   end

   // Read data register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit_any;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_loop_follows: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_ctrl) |=> loopback_en == $past(pwdata[14]))
      else $error("loopback does not follow control write");

   a_alias_loop: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_actl) |=> loopback_en == $past(pwdata[8]))
      else $error("loopback does not follow alias write");

   a_speed_duplex: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_actl) |=> force_speed_100 == $past(pwdata[6])
      && force_full_duplex == $past(pwdata[5]))
      else $error("speed or duplex does not follow alias write");

   a_an_enable: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_ctrl) |=> an_enable == $past(pwdata[12]))
      else $error("auto-negotiation enable does not follow write");

   a_power_down: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_actl) |=> power_down == $past(pwdata[11]))
      else $error("power-down does not follow alias write");

   a_power_ctrl: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_ctrl) |=> power_down == $past(pwdata[11]))
      else $error("power-down does not follow control write");

   a_restart_pulse: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_ctrl && pwdata[9] && !restart_busy)
      |=> an_restart [*1] ##0 ctrl_rd[9])
      else $error("restart not pulsed after write");

   a_xover_alias: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_ast) |=> alt_crossover_algorithm_select
      == $past(pwdata[15]) && ctrl_rd[5] == $past(pwdata[15]))
      else $error("crossover select alias mismatch");

   a_mdix_bits: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_ctrl) |=> {force_mdix, auto_mdix_disable}
      == $past(pwdata[4:3]))
      else $error("crossover wiring controls do not follow write");

   a_tx_led: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr && hit_ctrl) |=> {transmit_disable, led_disable}
      == $past(pwdata[1:0]))
      else $error("transmit or LED disable does not follow write");

   a_caps_read: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_setup && hit_stat) |=> prdata[15:11] == 5'h0f
      && prdata[3] && !prdata[0])
      else $error("capability bits read wrong");

   a_andone_read: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_setup && hit_stat) |=> prdata[5] == $past(st.an_done))
      else $error("negotiation complete bit read wrong");

   a_link_read: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_setup && hit_stat) |=> prdata[2] == $past(st.link_up))
      else $error("link status bit read wrong");

   a_id_read: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_setup && hit_idlo) |=> prdata == {16'h0000, PHY_ID_LOW})
      else $error("identifier low read wrong");

   a_ro_zero: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_setup && hit_ctrl) |=> prdata[15] == 1'b0 && prdata[10] == 1'b0
      && prdata[7:6] == 2'b00)
      else $error("unsupported control bits read nonzero");
endmodule : pphy_bank

// File: sim/pphy_link_partner.sv
// Behavioural cable link partner driving the PHY line state
`timescale 1ns/100ps
module pphy_link_partner #(
   parameter int AN_CYC = 5
) (
   // Clock and controls
   input wire logic pclk,
   input wire logic link_cmd,
   input wire logic power_down,
   input wire logic an_restart,
   // Line state
   output logic link_up,
   output logic an_complete
);
   int cnt = 0;
   // Quiet line until the bench plugs the cable in
   initial begin
      link_up = 1'b0;
      an_complete = 1'b0;
   end
   // Link needs cable and a powered PHY; a restart renegotiates
   always @(posedge pclk) begin
      link_up <= link_cmd & ~power_down;
      if (an_restart) begin
         an_complete <= 1'b0;
         cnt <= AN_CYC;
      end else if (!link_up) begin
         an_complete <= 1'b0; // Nothing to negotiate with
         cnt <= 0;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) an_complete <= 1'b1;
      end
   end
endmodule : pphy_link_partner

// File: sim/pphy_bank_bench.sv
// Register level testbench of the PHY basic control and status bank
`timescale 1ns/100ps
`include "pphy_defines.svh"
module pphy_bank_bench;
   localparam int HOLD = 4;
   localparam logic [15:0] ID = 16'h3c96; // Value is arbitrary
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [9:0] paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic link_cmd = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, irq, an_restart, link_up_in, an_complete_in;
   logic loopback_en, force_speed_100, force_full_duplex, an_enable;
   logic power_down, alt_crossover_algorithm_select, force_mdix;
   logic auto_mdix_disable, transmit_disable, led_disable;
   logic [9:0] ctl;
   int failures = 0;
   int comparisons = 0;
   int bl[10] = '{14, 13, 12, 11, 8, 5, 4, 3, 1, 0};
   // Control outputs in the order of their register bits
   assign ctl = {loopback_en, force_speed_100, an_enable, power_down,
      force_full_duplex, alt_crossover_algorithm_select, force_mdix,
      auto_mdix_disable, transmit_disable, led_disable};
   // 125 MHz clock
   initial begin
      forever #4 pclk = ~pclk;
   end
   pphy_bank #(.PHY_ID_LOW(ID), .RESTART_HOLD(HOLD)) u_dut (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .link_up_in, .an_complete_in, .loopback_en, .force_speed_100,
      .force_full_duplex, .an_enable, .power_down, .an_restart,
      .alt_crossover_algorithm_select, .force_mdix, .auto_mdix_disable,
      .transmit_disable, .led_disable, .irq);
   pphy_link_partner u_lp (.pclk, .link_cmd, .power_down, .an_restart,
      .link_up(link_up_in), .an_complete(an_complete_in));
   // ------------------------------------------------------------------
   // Checking and APB tasks
   // ------------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   // One APB transfer, entered just after a rising edge
   task xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n == 20) begin
         failures++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer
   task wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, {idx, 2'b00}, d);
   endtask : wr
   task rc(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, {idx, 2'b00}, 32'h0);
      check(rd, exp);
   endtask : rc
   // Look at irq (pick 0) or an_restart (pick 1) mid-cycle, then realign
   task flag(input logic pick, input logic exp);
      @(negedge pclk);
      check({31'h0, pick ? an_restart : irq}, {31'h0, exp});
      @(posedge pclk);
   endtask : flag
   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({22'h0, ctl}, 32'h090);
      rc(`PPHY_IDX_CTRL, 32'h1020);
      rc(`PPHY_IDX_STAT, 32'h7808);
      rc(`PPHY_IDX_IDLO, {16'h0, ID});
      check({31'h0, err}, 32'h0);
      wr(`PPHY_IDX_CTRL, 32'hffff_84c4);
      rc(`PPHY_IDX_CTRL, 32'h0004);
      // Each control bit with an output, except restart bit 9, alone reaches only its own output
      for (int i = 0; i < 10; i++) begin
         wr(`PPHY_IDX_CTRL, 32'h1 << bl[i]);
         rc(`PPHY_IDX_CTRL, 32'h1 << bl[i]);
         check({22'h0, ctl}, 32'h1 << (9 - i));
      end
      wr(`PPHY_IDX_STAT, 32'hffff);
      rc(`PPHY_IDX_STAT, 32'h7808);
      wr(`PPHY_IDX_IDLO, 32'h0);
      rc(`PPHY_IDX_IDLO, {16'h0, ID});
      // Link comes up; event is held while masked
      wr(`PPHY_IDX_CTRL, 32'h1020);
      wr(`PPHY_IDX_ISTAT, 32'h3);
      link_cmd <= 1'b1;
      repeat (6) @(posedge pclk);
      rc(`PPHY_IDX_STAT, 32'h780c);
      rc(`PPHY_IDX_AST, 32'h8020);
      rc(`PPHY_IDX_ISTAT, 32'h1);
      flag(1'b0, 1'b0);
      wr(`PPHY_IDX_IMASK, 32'h1);
      flag(1'b0, 1'b1);
      wr(`PPHY_IDX_ISTAT, 32'h1);
      flag(1'b0, 1'b0);
      // Restart self-clears and the partner completes negotiation
      wr(`PPHY_IDX_CTRL, 32'h1220);
      flag(1'b1, 1'b1);
      rc(`PPHY_IDX_CTRL, 32'h1220);
      repeat (20) @(posedge pclk);
      rc(`PPHY_IDX_CTRL, 32'h1020);
      rc(`PPHY_IDX_STAT, 32'h782c);
      rc(`PPHY_IDX_AST, 32'h8060);
      rc(`PPHY_IDX_ISTAT, 32'h2);
      // Both alias registers share state with the control register
      wr(`PPHY_IDX_ACTL, 32'h8180);
      rc(`PPHY_IDX_CTRL, 32'h5021);
      rc(`PPHY_IDX_ACTL, 32'h8180);
      wr(`PPHY_IDX_AST, 32'h0);
      rc(`PPHY_IDX_CTRL, 32'h5001);
      // Power-down takes the link and negotiation away
      wr(`PPHY_IDX_CTRL, 32'h0800);
      repeat (6) @(posedge pclk);
      check({22'h0, ctl}, 32'h040);
      rc(`PPHY_IDX_STAT, 32'h7808);
      // Unmapped addresses are refused
      xfer(1'b0, 10'h00c, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      xfer(1'b1, 10'h3fc, 32'hffff);
      check({31'h0, err}, 32'h1);
      rc(`PPHY_IDX_CTRL, 32'h0800);
      results();
   end
endmodule : pphy_bank_bench
